/* verilog/fae_engine.sv */
// Contract
// - Each aligned 16-byte unit gets check bits stored with it on programming.
// - Programming also writes a per-unit disable flag, set by the program history when double detect is off.
// - A line holds 16 or 32 units by buffer option, each with own check data.
// - The program buffer maps to one line; check logic acts on buffer-to-line moves.
// - First program after erase covers the whole unit, unwritten bytes included.
// - Protection is tracked per aligned 16-byte unit, never finer.
// - Without double detect, a second program to a unit since erase disables its protection.
// - With double detect on, single errors are corrected and double errors reported.
// - With double detect on, the disable flag serves as ninth check bit.
// - With double detect on, programming a unit twice gives a program error.
// - Array reads pass through the decoder into a unit-sized read buffer.
// - Single-bit data errors are corrected before data reaches the host.
// - A single-bit error in the stored check bits is tolerated; data stays right.
// - Units with protection off are returned raw, without checking.
// - An enabled interrupt output flags single or double errors on reads.
// - A double error holds the read strobe low.
// - Without double detect, 8 check bits plus a separate enable flag per unit.
// - Sector erase returns all unit flags in the sector to enabled.
// - A configuration bit picks correction only or correction plus double detect.
`timescale 1ns/100ps
`default_nettype none
module fae_engine (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [fae_pkg::AXW-1:0] i_axi_awaddr,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [fae_pkg::AXW-1:0] i_axi_araddr,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  input wire logic i_prog_valid,
  output logic o_prog_ready,
  input wire fae_pkg::fae_prog_t i_prog,
  output logic o_prog_err,
  input wire logic i_erase_valid,
  input wire logic [fae_pkg::SECW-1:0] i_erase_sector,
  output logic o_arr_wr_valid,
  output fae_pkg::fae_arr_t o_arr_wr,
  input wire logic i_arr_rd_valid,
  input wire fae_pkg::fae_arr_t i_arr_rd,
  input wire logic i_xfer_end,
  output logic o_rd_valid,
  output logic [fae_pkg::DW-1:0] o_rd_data,
  output logic o_read_strobe_out,
  output logic o_int_n
);
  import fae_pkg::*;

  typedef struct packed {
    logic ded_en;
    logic int_en;
    logic b512;
    logic sgl;
    logic dbl;
    logic perr;
    logic dis;
    logic aw_hold;
    logic [AXW-1:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NU-1:0] used;
    logic wr_valid;
    fae_arr_t wr;
    logic perr_p;
    logic rd_valid;
    logic [DW-1:0] rd_data;
    logic stall;
  } fae_st_t;

  fae_st_t q;
  fae_st_t n;
  logic pacc;
  logic wr_fire;
  logic [UW-1:0] uidx;
  logic [DW-1:0] merged;
  logic [DW-1:0] dec_data;
  logic dec_sgl;
  logic dec_dbl;
  logic dec_raw;

  fae_ecc_dec u_dec (
    .i_data(i_arr_rd.data),
    .i_chk(i_arr_rd.chk),
    .i_ded_en(q.ded_en),
    .o_data(dec_data),
    .o_sgl(dec_sgl),
    .o_dbl(dec_dbl),
    .o_raw(dec_raw)
  );

  assign o_axi_awready = !q.aw_hold && !q.bvalid;
  assign o_axi_wready = !q.w_hold && !q.bvalid;
  assign o_axi_arready = !q.rvalid;
  assign o_prog_ready = !q.wr_valid;
  assign pacc = i_prog_valid && o_prog_ready;
  assign uidx = fae_unit(i_prog.line, i_prog.slot, q.b512);
  assign merged = fae_merge(i_prog.data, i_prog.be);

  always_comb begin
    n = q;
    n.perr_p = 1'b0;
    n.wr_valid = 1'b0;
    n.rd_valid = 1'b0;
    wr_fire = 1'b0;
    if (i_axi_awvalid && o_axi_awready) begin
      n.aw_hold = 1'b1;
      n.aw_addr = i_axi_awaddr;
    end
    if (i_axi_wvalid && o_axi_wready) begin
      n.w_hold = 1'b1;
      n.w_data = i_axi_wdata;
      n.w_strb = i_axi_wstrb;
    end
    if (q.bvalid && i_axi_bready) n.bvalid = 1'b0;
    if (q.aw_hold && q.w_hold) begin
      wr_fire = 1'b1;
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OK;
      unique case (q.aw_addr)
        A_CTRL: begin
          if (q.w_strb[0]) begin
            n.ded_en = q.w_data[C_DED];
            n.int_en = q.w_data[C_INT];
            n.b512 = q.w_data[C_B512];
          end
        end
        A_STAT: begin
          if (q.w_strb[0]) begin
            n.sgl = q.sgl && !q.w_data[S_SGL];
            n.dbl = q.dbl && !q.w_data[S_DBL];
            n.perr = q.perr && !q.w_data[S_PERR];
            n.dis = q.dis && !q.w_data[S_DIS];
          end
        end
        default: n.bresp = RESP_SLV;
      endcase
    end
    if (q.rvalid && i_axi_rready) n.rvalid = 1'b0;
    if (i_axi_arvalid && o_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OK;
      n.rdata = '0;
      unique case (i_axi_araddr)
        A_CTRL: begin
          n.rdata[C_DED] = q.ded_en;
          n.rdata[C_INT] = q.int_en;
          n.rdata[C_B512] = q.b512;
        end
        A_STAT: begin
          n.rdata[S_SGL] = q.sgl;
          n.rdata[S_DBL] = q.dbl;
          n.rdata[S_PERR] = q.perr;
          n.rdata[S_DIS] = q.dis;
        end
        default: n.rresp = RESP_SLV;
      endcase
    end
    // Erase clears history per unit of the sector
    if (i_erase_valid) begin
      for (int i = 0; i < NU; i++) begin
        if (SECW'(i / UPS) == i_erase_sector) n.used[i] = 1'b0;
      end
    end
    if (pacc) begin
      if (q.used[uidx] && q.ded_en) begin
        n.perr_p = 1'b1;
        n.perr = 1'b1;
      end else begin
        n.wr_valid = 1'b1;
        n.wr.unit = uidx;
        n.wr.data = merged;
        n.wr.chk[CW-1:0] = fae_gen(merged);
        if (q.ded_en) begin
          n.wr.chk[CW] = ^{merged, fae_gen(merged)};
        end else begin
          n.wr.chk[CW] = q.used[uidx];
          if (q.used[uidx]) n.dis = 1'b1;
        end
        n.used[uidx] = 1'b1;
      end
    end
    if (i_xfer_end) n.stall = 1'b0;
    if (i_arr_rd_valid) begin
      n.rd_valid = 1'b1;
      n.rd_data = dec_data;
      if (dec_sgl) n.sgl = 1'b1;
      if (dec_dbl) begin
        n.dbl = 1'b1;
        n.stall = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_axi_bvalid = q.bvalid;
  assign o_axi_bresp = q.bresp;
  assign o_axi_rvalid = q.rvalid;
  assign o_axi_rdata = q.rdata;
  assign o_axi_rresp = q.rresp;
  assign o_prog_err = q.perr_p;
  assign o_arr_wr_valid = q.wr_valid;
  assign o_arr_wr = q.wr;
  assign o_rd_valid = q.rd_valid;
  assign o_rd_data = q.rd_data;
  assign o_read_strobe_out = q.rd_valid && !q.stall;
  assign o_int_n = !(q.int_en && (q.sgl || q.dbl));

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  chk_dbl_stall: assert property (i_arr_rd_valid && dec_dbl && !i_xfer_end |=> !o_read_strobe_out && q.stall)
    else $error("strobe not held low after double error");
  chk_twice_err: assert property (pacc && q.ded_en && q.used[uidx] |=> o_prog_err && !o_arr_wr_valid)
    else $error("second program did not fail");
  chk_twice_dis: assert property (pacc && !q.ded_en && q.used[uidx] |=> o_arr_wr_valid && o_arr_wr.chk[CW])
    else $error("second program left protection on");
  chk_first_en: assert property (pacc && !q.ded_en && !q.used[uidx] && !i_erase_valid |=> !o_arr_wr.chk[CW])
    else $error("first program disabled protection");
  chk_nine_parity: assert property (o_arr_wr_valid && $past(q.ded_en) |-> ^{o_arr_wr.data, o_arr_wr.chk} == 1'b0)
    else $error("ninth check bit wrong");
  chk_raw_pass: assert property (i_arr_rd_valid && dec_raw |=> o_rd_valid && o_rd_data == $past(i_arr_rd.data))
    else $error("disabled unit not returned raw");
  chk_int_flag: assert property (i_arr_rd_valid && (dec_sgl || dec_dbl) && q.int_en && !wr_fire |=> !o_int_n)
    else $error("interrupt not raised on read error");
  chk_erase_clr: assert property (i_erase_valid && !pacc |=> q.used[$past(i_erase_sector) * UPS] == 1'b0)
    else $error("erase left unit flag set");
  chk_whole_unit: assert property (pacc && !(q.used[uidx] && q.ded_en) |=> o_arr_wr.unit == $past(uidx)
                                   && o_arr_wr.chk[CW-1:0] == fae_gen(o_arr_wr.data))
    else $error("check bits not over whole unit");
  chk_wr_resp: assert property (i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready |-> ##[1:2] o_axi_bvalid)
    else $error("write response missing");

  cov_dbl_stall: cover property (i_arr_rd_valid && dec_dbl ##1 !o_read_strobe_out);
  cov_prog_err: cover property (o_prog_err);
  cov_sgl_fix: cover property (i_arr_rd_valid && dec_sgl ##1 o_rd_valid);
  cov_second_prog: cover property (pacc && !q.ded_en && q.used[uidx]);
endmodule // fae_engine
`default_nettype wire

/* pkg/fae_pkg.sv */
`default_nettype none
package fae_pkg;
  localparam int DW = 128;
  localparam int CW = 8;
  localparam int BYTES = 16;
  localparam int NU = 128;
  localparam int UW = 7;
  localparam int LW = 2;
  localparam int SW = 5;
  localparam int SECW = 2;
  localparam int UPS = 32;
  localparam int AXW = 4;
  localparam logic [AXW-1:0] A_CTRL = 4'h0;
  localparam logic [AXW-1:0] A_STAT = 4'h4;
  localparam int C_DED = 0;
  localparam int C_INT = 1;
  localparam int C_B512 = 2;
  localparam int S_SGL = 0;
  localparam int S_DBL = 1;
  localparam int S_PERR = 2;
  localparam int S_DIS = 3;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLV = 2'h2;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  typedef struct packed {
    logic [LW-1:0] line;
    logic [SW-1:0] slot;
    logic [DW-1:0] data;
    logic [BYTES-1:0] be;
  } fae_prog_t;

  typedef struct packed {
    logic [UW-1:0] unit;
    logic [DW-1:0] data;
    logic [CW:0] chk;
  } fae_arr_t;

  // Code position of data bit i, skipping powers of two
  function automatic logic [CW-1:0] fae_pos(input int i);
    int p;
    int k;
    logic [CW-1:0] r;
    r = '0;
    k = 0;
    for (p = 3; p <= DW + CW; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (k == i) r = CW'(p);
        k++;
      end
    end
    return r;
  endfunction

  function automatic logic [CW-1:0] fae_gen(input logic [DW-1:0] d);
    logic [CW-1:0] r;
    r = '0;
    for (int i = 0; i < DW; i++) begin
      if (d[i]) r = r ^ fae_pos(i);
    end
    return r;
  endfunction

  function automatic logic [UW-1:0] fae_unit(input logic [LW-1:0] line, input logic [SW-1:0] slot,
                                            input logic b512);
    return b512 ? {line, slot} : {1'b0, line, slot[SW-2:0]};
  endfunction

  function automatic logic [DW-1:0] fae_merge(input logic [DW-1:0] d, input logic [BYTES-1:0] be);
    logic [DW-1:0] r;
    r = d;
    for (int b = 0; b < BYTES; b++) begin
      if (!be[b]) r[b*8 +: 8] = ERASED_BYTE;
    end
    return r;
  endfunction
endpackage
`default_nettype wire

/* verilog/fae_ecc_dec.sv */
`timescale 1ns/100ps
`default_nettype none
module fae_ecc_dec (
  input wire logic [fae_pkg::DW-1:0] i_data,
  input wire logic [fae_pkg::CW:0] i_chk,
  input wire logic i_ded_en,
  output logic [fae_pkg::DW-1:0] o_data,
  output logic o_sgl,
  output logic o_dbl,
  output logic o_raw
);
  import fae_pkg::*;
  logic [CW-1:0] syn;
  logic par;

  always_comb begin
    syn = fae_gen(i_data) ^ i_chk[CW-1:0];
    par = ^{i_data, i_chk};
    o_raw = !i_ded_en && i_chk[CW];
    o_data = i_data;
    o_sgl = 1'b0;
    o_dbl = 1'b0;
    if (!o_raw) begin
      if (i_ded_en) begin
        o_sgl = par;
        o_dbl = !par && (syn != '0);
      end else begin
        o_sgl = (syn != '0);
      end
      // Syndrome on a check position leaves data as is
      if (o_sgl) begin
        for (int i = 0; i < DW; i++) begin
          if (fae_pos(i) == syn) o_data[i] = ~i_data[i];
        end
      end
    end
  end
endmodule // fae_ecc_dec
`default_nettype wire

/* sim/fae_arr_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fae_arr_model
  import fae_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_wr_valid,
  input wire fae_pkg::fae_arr_t i_wr,
  input wire logic i_req,
  input wire logic [fae_pkg::UW-1:0] i_unit,
  input wire logic [fae_pkg::DW-1:0] i_dflip,
  input wire logic [fae_pkg::CW:0] i_cflip,
  output logic o_rd_valid,
  output fae_pkg::fae_arr_t o_rd
);
  fae_arr_t mem_q [NU];
  initial o_rd_valid = 1'b0;
  initial o_rd = '0;
  always @(posedge i_mclk) begin
    if (i_wr_valid) begin
      mem_q[i_wr.unit] <= i_wr;
    end
    o_rd_valid <= i_req;
    if (i_req) begin
      o_rd <= '{unit: i_unit, data: mem_q[i_unit].data ^ i_dflip, chk: mem_q[i_unit].chk ^ i_cflip};
    end else begin
      o_rd <= ~o_rd;
    end
  end
endmodule // fae_arr_model
`default_nettype wire

/* sim/fae_engine_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module fae_engine_tb;
  import fae_pkg::*;
  typedef struct packed {
    logic [DW-1:0] df;
    logic [CW:0] cf;
  } fae_row_t;
  localparam logic [DW-1:0] D = 128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, pv = 0, ev = 0, xe = 0, rq = 0;
  logic [AXW-1:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd32, o_rdat;
  logic [1:0] rsp, o_br, o_rr;
  logic [SECW-1:0] esec = '0;
  fae_prog_t pg = '0;
  logic [UW-1:0] ru = '0;
  logic [DW-1:0] rdf = '0, o_rdd;
  logic [CW:0] rcf = '0;
  logic o_awr, o_wr, o_bv, o_arr, o_rv, o_prdy, o_perr, o_awv, mv, o_rdv, o_stb, o_int_n;
  fae_arr_t o_aw, mr;
  int failures = 0, cmp_count = 0, cyc = 0;
  fae_row_t rows [4] = '{'{'0, '0}, '{128'h20, '0}, '{{1'b1, 127'h0}, '0}, '{'0, 9'h008}};
  always #25 clk = ~clk;
  fae_engine fae_engine_inst (.i_mclk(clk), .i_rst(rst), .i_axi_awvalid(awv), .o_axi_awready(o_awr),
    .i_axi_awaddr(awa), .i_axi_wvalid(wv), .o_axi_wready(o_wr), .i_axi_wdata(wd), .i_axi_wstrb(4'hf),
    .o_axi_bvalid(o_bv), .i_axi_bready(bry), .o_axi_bresp(o_br), .i_axi_arvalid(arv),
    .o_axi_arready(o_arr), .i_axi_araddr(ara), .o_axi_rvalid(o_rv), .i_axi_rready(rry),
    .o_axi_rdata(o_rdat), .o_axi_rresp(o_rr), .i_prog_valid(pv), .o_prog_ready(o_prdy), .i_prog(pg),
    .o_prog_err(o_perr), .i_erase_valid(ev), .i_erase_sector(esec), .o_arr_wr_valid(o_awv),
    .o_arr_wr(o_aw), .i_arr_rd_valid(mv), .i_arr_rd(mr), .i_xfer_end(xe), .o_rd_valid(o_rdv),
    .o_rd_data(o_rdd), .o_read_strobe_out(o_stb), .o_int_n(o_int_n));
  fae_arr_model fae_arr_model_inst (.i_mclk(clk), .i_wr_valid(o_awv), .i_wr(o_aw), .i_req(rq),
    .i_unit(ru), .i_dflip(rdf), .i_cflip(rcf), .o_rd_valid(mv), .o_rd(mr));
  task finish_test;
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      finish_test;
    end
  end
  task axw(input logic [AXW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    awv <= 1; wv <= 1; awa <= a; wd <= d; bry <= 1;
    forever begin
      @(posedge clk);
      if (awv && o_awr) awv <= 0;
      if (wv && o_wr) wv <= 0;
      if (o_bv) begin rsp = o_br; bry <= 0; break; end
    end
  endtask
  task axr(input logic [AXW-1:0] a);
    @(posedge clk);
    arv <= 1; ara <= a; rry <= 1;
    forever begin
      @(posedge clk);
      if (arv && o_arr) arv <= 0;
      if (o_rv) begin rd32 = o_rdat; rsp = o_rr; rry <= 0; break; end
    end
  endtask
  task prog(input logic [LW-1:0] l, input logic [SW-1:0] s, input logic [BYTES-1:0] b);
    @(posedge clk);
    pv <= 1; pg <= '{line: l, slot: s, data: D, be: b};
    @(posedge clk);
    pv <= 0;
    #1;
  endtask
  task rd(input logic [UW-1:0] u, input logic [DW-1:0] df, input logic [CW:0] cf);
    @(posedge clk);
    rq <= 1; ru <= u; rdf <= df; rcf <= cf;
    @(posedge clk);
    rq <= 0;
    @(posedge clk);
    #1;
  endtask
  task pulse(input logic e);
    @(posedge clk);
    if (e) ev <= 1; else xe <= 1;
    @(posedge clk);
    ev <= 0; xe <= 0;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk); #1;
    `CK("prog_ready", 1'b1, o_prdy)
    `CK("int_n", 1'b1, o_int_n)
    axr(A_CTRL); `CK("ctrl", 32'h0, rd32)
    axw(A_CTRL, 32'h2); `CK("bresp", RESP_OK, rsp)
    prog(2'd1, 5'd17, '1); `CK("unit", 7'h11, o_aw.unit)
    `CK("wr_data", D, o_aw.data)
    `CK("dis_flag", 1'b0, o_aw.chk[CW])
    foreach (rows[i]) begin
      rd(7'h11, rows[i].df, rows[i].cf); `CK("rd_data", D, o_rdd)
      `CK("strobe", 1'b1, o_stb)
      `CK("rd_valid", 1'b1, o_rdv)
    end
    `CK("int_n", 1'b0, o_int_n)
    axr(A_STAT); `CK("sgl", 1'b1, rd32[S_SGL])
    axw(A_STAT, 32'hf); `CK("int_n", 1'b1, o_int_n)
    prog(2'd1, 5'd17, '1); `CK("dis_flag", 1'b1, o_aw.chk[CW])
    rd(7'h11, 128'h1, '0); `CK("raw", D ^ 128'h1, o_rdd)
    pulse(1'b1);
    prog(2'd1, 5'd17, '1); `CK("dis_flag", 1'b0, o_aw.chk[CW])
    prog(2'd0, 5'd3, 16'h00ff); `CK("merge", {64'hffff_ffff_ffff_ffff, D[63:0]}, o_aw.data)
    `CK("unit", 7'h03, o_aw.unit)
    axw(A_CTRL, 32'h3);
    axw(A_STAT, 32'hf);
    prog(2'd0, 5'd2, '1); `CK("parity", 1'b0, ^o_aw.chk ^ ^o_aw.data)
    prog(2'd0, 5'd2, '1); `CK("prog_err", 1'b1, o_perr)
    `CK("no_write", 1'b0, o_awv)
    rd(7'h02, 128'h10, '0); `CK("ded_fix", D, o_rdd)
    rd(7'h02, 128'h3, '0); `CK("stall", 1'b0, o_stb)
    rd(7'h02, '0, '0); `CK("stall", 1'b0, o_stb)
    axr(A_STAT); `CK("dbl", 1'b1, rd32[S_DBL])
    pulse(1'b0);
    rd(7'h02, '0, '0); `CK("strobe", 1'b1, o_stb)
    axw(A_CTRL, 32'h4);
    prog(2'd1, 5'd17, '1); `CK("unit512", 7'h31, o_aw.unit)
    axr(4'h8); `CK("rresp", RESP_SLV, rsp)
    finish_test;
  end
endmodule // fae_engine_tb
`default_nettype wire
